// ===== src/pcs_pkg.sv
/*
 * Shared constants for the loop control and base clock select block:
 * register indices, field positions, reset values, switchover counts,
 * and the host's APB register map.
 * Assumes both ends and the bench import this package.
 */
package pcs_pkg;
    // ------------------------------------------------------------
    // Device register indices
    // ------------------------------------------------------------
    localparam logic [1:0] LOOP_CTL_IDX = 2'h0;
    localparam logic [1:0] BW_CTL_IDX = 2'h1;
    localparam logic [1:0] VCO_RANGE_IDX = 2'h2;

    // ------------------------------------------------------------
    // Loop control register fields
    // ------------------------------------------------------------
    localparam int IRQ_EN_BIT = 7;
    localparam int FLAG_BIT = 6;
    localparam int LOOP_ON_BIT = 5;
    localparam int BASE_SEL_BIT = 4;
    localparam int PRE_LSB = 2;
    localparam int VPR_LSB = 0;

    // ------------------------------------------------------------
    // Bandwidth control register fields
    // ------------------------------------------------------------
    localparam int AUTO_BIT = 7;
    localparam int LOCK_BIT = 6;
    localparam int ACQ_BIT = 5;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic LOOP_ON_RST = 1'b1;
    localparam logic [7:0] VCO_RANGE_RST = 8'h40;

    // ------------------------------------------------------------
    // Switchover timing
    // ------------------------------------------------------------
    localparam int SWITCH_EDGES_DEF = 3;
    localparam int SW_CNT_W = 4;

    typedef enum logic [1:0] {
        PCS_SW_RUN = 2'b01,
        PCS_SW_HOLD = 2'b10
    } pcs_sw_e;

    // ------------------------------------------------------------
    // Host APB map
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] PIN_OFS = 8'h08;
    localparam int CMD_IDX_LSB = 8;
    localparam int CMD_WR_BIT = 16;
    localparam int STAT_BUSY_BIT = 8;
    localparam int PIN_OSC_EN_BIT = 0;
    localparam int PIN_RUN_STOP_BIT = 1;
endpackage

// ===== src/pcs_link_if.sv
/*
 * Register access link between the host controller and the device.
 * Assumes both ends share clk_sys; req is a one-cycle strobe, ack answers it.
 */
interface pcs_link_if;
    logic req;
    logic wr;
    logic [1:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic ack;

    modport dev (
        input req,
        input wr,
        input idx,
        input wdata,
        output rdata,
        output ack
    );

    modport ctl (
        output req,
        output wr,
        output idx,
        output wdata,
        input rdata,
        input ack
    );
endinterface

// ===== src/pcs_loop_dev.sv
/*
 * Loop control register, bandwidth and range registers, lock-change flag
 * and glitch-free base clock selector with divide by two.
 * Assumes crystal_clock, vco_clock and vco_locked are synchronous to clk_sys
 * and run well below half its rate; the host drives the link.
 */
module pcs_loop_dev #(
    parameter int SWITCH_EDGES = pcs_pkg::SWITCH_EDGES_DEF
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    pcs_link_if.dev link,
    input wire logic crystal_clock,
    input wire logic vco_clock,
    input wire logic vco_locked,
    input wire logic oscillator_enable_in,
    input wire logic osc_run_in_stop,
    output logic base_clock_out,
    output logic lock_interrupt,
    output logic osc_enable_out,
    output logic loop_enable_out
);
    import pcs_pkg::*;

    if (SWITCH_EDGES < 1 || SWITCH_EDGES >= (1 << SW_CNT_W)) begin : g_chk
        $error("SWITCH_EDGES out of range");
    end

    typedef struct packed {
        logic irq_en;
        logic flag;
        logic loop_on;
        logic base_sel;
        logic [1:0] pre;
        logic [1:0] vpr;
        logic auto_bw;
        logic acq;
        logic lock;
        logic [7:0] vrs;
        logic active_sel;
        pcs_sw_e st;
        logic [SW_CNT_W-1:0] xcnt;
        logic [SW_CNT_W-1:0] vcnt;
        logic xprev;
        logic vprev;
        logic base;
        logic irq;
        logic osc_en;
        logic loop_en;
        logic [7:0] rdata;
        logic ack;
    } pcs_dev_s;

    localparam logic [SW_CNT_W-1:0] EDGES = SWITCH_EDGES[SW_CNT_W-1:0];

    pcs_dev_s s_q;
    pcs_dev_s s_d;

    // Saturating edge counter
    function automatic logic [SW_CNT_W-1:0] bump(input logic [SW_CNT_W-1:0] c, input logic rise);
        bump = (rise && c < EDGES) ? c + 1'b1 : c;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic xrise;
        logic vrise;
        logic arise;
        logic [7:0] loop_rd;
        xrise = crystal_clock & ~s_q.xprev;
        vrise = vco_clock & ~s_q.vprev;
        arise = s_q.active_sel ? vrise : xrise;
        loop_rd = {s_q.irq_en & s_q.auto_bw, s_q.flag & s_q.auto_bw, s_q.loop_on, s_q.base_sel, s_q.pre, s_q.vpr};
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.xprev = crystal_clock;
        s_d.vprev = vco_clock;
        s_d.lock = s_q.auto_bw & vco_locked;

        if (link.req) begin
            s_d.ack = 1'b1;
            if (!link.wr) begin
                case (link.idx)
                    LOOP_CTL_IDX: begin
                        s_d.rdata = loop_rd;
                        s_d.flag = 1'b0;
                    end
                    BW_CTL_IDX: s_d.rdata = {s_q.auto_bw, s_q.lock, s_q.acq, 5'h00};
                    VCO_RANGE_IDX: s_d.rdata = s_q.vrs;
                    default: s_d.rdata = 8'h00;
                endcase
            end else begin
                case (link.idx)
                    LOOP_CTL_IDX: begin
                        if (s_q.auto_bw) begin
                            s_d.irq_en = link.wdata[IRQ_EN_BIT];
                        end
                        if (!s_q.loop_on) begin
                            s_d.pre = link.wdata[PRE_LSB+:2];
                            s_d.vpr = link.wdata[VPR_LSB+:2];
                        end
                        s_d.loop_on = link.wdata[LOOP_ON_BIT] | s_q.base_sel;
                        s_d.base_sel = link.wdata[BASE_SEL_BIT] & s_q.loop_on;
                    end
                    BW_CTL_IDX: begin
                        s_d.auto_bw = link.wdata[AUTO_BIT];
                        if (!s_q.auto_bw) begin
                            s_d.acq = link.wdata[ACQ_BIT];
                        end
                    end
                    VCO_RANGE_IDX: begin
                        if (!s_q.loop_on) begin
                            s_d.vrs = link.wdata;
                        end
                    end
                    default: ;
                endcase
            end
        end

        // A toggle in the same cycle as a clearing read still sets the flag
        if (s_q.auto_bw && s_d.lock != s_q.lock) begin
            s_d.flag = 1'b1;
        end
        if (!s_d.auto_bw) begin
            s_d.flag = 1'b0;
            s_d.irq_en = 1'b0;
        end
        if (!s_d.loop_on || s_d.vrs == 8'h00) begin
            s_d.base_sel = 1'b0;
        end

        // ------------------------------------------------------------
        // Base clock selector
        // ------------------------------------------------------------
        case (s_q.st)
            PCS_SW_RUN: begin
                if (s_q.base_sel != s_q.active_sel) begin
                    s_d.st = PCS_SW_HOLD;
                    s_d.xcnt = '0;
                    s_d.vcnt = '0;
                end else if (arise) begin
                    s_d.base = ~s_q.base;
                end
            end
            PCS_SW_HOLD: begin
                s_d.xcnt = bump(s_q.xcnt, xrise);
                s_d.vcnt = bump(s_q.vcnt, vrise);
                if (s_q.xcnt == EDGES && s_q.vcnt == EDGES) begin
                    s_d.active_sel = s_q.base_sel;
                    s_d.st = PCS_SW_RUN;
                end
            end
            default: s_d.st = PCS_SW_RUN;
        endcase

        s_d.irq = s_d.flag & s_d.irq_en;
        s_d.osc_en = osc_run_in_stop | oscillator_enable_in;
        s_d.loop_en = oscillator_enable_in & s_d.loop_on & (s_d.vrs != 8'h00);

        if (sys_rst) begin
            s_d = '0;
            s_d.loop_on = LOOP_ON_RST;
            s_d.base_sel = 1'b0;
            // Keep tracking the sources so no false edge follows reset
            s_d.xprev = crystal_clock;
            s_d.vprev = vco_clock;
            s_d.vrs = VCO_RANGE_RST;
            s_d.st = PCS_SW_RUN;
        end
    end

    always_ff @(posedge clk_sys) begin
        s_q <= s_d;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign link.rdata = s_q.rdata;
    assign link.ack = s_q.ack;
    assign base_clock_out = s_q.base;
    assign lock_interrupt = s_q.irq;
    assign osc_enable_out = s_q.osc_en;
    assign loop_enable_out = s_q.loop_en;
endmodule

// ===== src/pcs_apb_ctl.sv
/*
 * Host controller: APB slave holding a command register, status and pin
 * control, issuing single register accesses over the link.
 * Assumes an APB master on clk_sys and the device on the link.
 */
module pcs_apb_ctl (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic oscillator_enable_out,
    output logic osc_run_in_stop_out,
    pcs_link_if.ctl link
);
    import pcs_pkg::*;

    typedef struct packed {
        logic req;
        logic wr;
        logic [1:0] idx;
        logic [7:0] wdata;
        logic busy;
        logic [7:0] rdata;
        logic osc_en;
        logic run_stop;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pcs_ctl_s;

    pcs_ctl_s s_q;
    pcs_ctl_s s_d;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic setup;
        logic access;
        setup = psel & ~penable;
        access = psel & penable & s_q.pready;
        s_d = s_q;
        s_d.req = 1'b0;
        s_d.pready = 1'b0;

        if (setup) begin
            s_d.pready = 1'b1;
            s_d.pslverr = 1'b0;
            case (paddr)
                CMD_OFS: s_d.prdata = {15'h0000, s_q.wr, 6'h00, s_q.idx, s_q.wdata};
                STAT_OFS: s_d.prdata = {23'h000000, s_q.busy, s_q.rdata};
                PIN_OFS: s_d.prdata = {30'h00000000, s_q.run_stop, s_q.osc_en};
                default: begin
                    s_d.prdata = 32'h00000000;
                    s_d.pslverr = 1'b1;
                end
            endcase
        end

        // Accesses are issued only on an explicit command write
        if (access && pwrite && paddr == CMD_OFS && !s_q.busy) begin
            s_d.req = 1'b1;
            s_d.busy = 1'b1;
            s_d.wr = pwdata[CMD_WR_BIT];
            s_d.idx = pwdata[CMD_IDX_LSB+:2];
            s_d.wdata = pwdata[7:0];
        end
        if (access && pwrite && paddr == PIN_OFS) begin
            s_d.osc_en = pwdata[PIN_OSC_EN_BIT];
            s_d.run_stop = pwdata[PIN_RUN_STOP_BIT];
        end

        if (link.ack && s_q.busy) begin
            s_d.busy = 1'b0;
            if (!s_q.wr) begin
                s_d.rdata = link.rdata;
            end
        end

        if (sys_rst) begin
            s_d = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        s_q <= s_d;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign link.req = s_q.req;
    assign link.wr = s_q.wr;
    assign link.idx = s_q.idx;
    assign link.wdata = s_q.wdata;
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign oscillator_enable_out = s_q.osc_en;
    assign osc_run_in_stop_out = s_q.run_stop;
endmodule

// ===== verification/pcs_assertions.sv
/*
 * Link checker: request, answer and read data between host and device.
 * Assumes one clock domain; instantiated beside the link by the bench.
 */
module pcs_assertions (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic req,
    input wire logic wr,
    input wire logic [1:0] idx,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic ack
);
    timeunit 1ns;
    timeprecision 1ps;
    import pcs_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic rd_q, au_q, auto_q, w0_q, rd_ack;
    logic [1:0] ri_q;
    // ----------------------------------------
    // Helper state: last request and auto mode
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rd_q <= 1'b0;
            ri_q <= 2'h0;
            au_q <= 1'b0;
            auto_q <= 1'b0;
            w0_q <= 1'b0;
        end else begin
            rd_q <= req && !wr;
            ri_q <= idx;
            au_q <= auto_q;
            if (req && wr && idx == BW_CTL_IDX) auto_q <= wdata[AUTO_BIT];
            if (req && wr && idx == LOOP_CTL_IDX) w0_q <= 1'b1;
        end
    end
    assign rd_ack = ack && rd_q;
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_ack_after_req: assert property (req |=> ack)
        else $error("no answer one cycle after request");
    a_ack_has_req: assert property (ack |-> $past(req))
        else $error("answer without request");
    a_rdata_holds: assert property (!rd_ack |-> $stable(rdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (rd_ack && ri_q == 2'h3 |-> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_irq_manual_zero: assert property (rd_ack && ri_q == LOOP_CTL_IDX && !au_q |-> rdata[7:6] == 2'b00)
        else $error("enable or flag visible in manual mode");
    a_sel_needs_on: assert property (rd_ack && ri_q == LOOP_CTL_IDX |-> !(rdata[BASE_SEL_BIT] && !rdata[LOOP_ON_BIT]))
        else $error("select set with loop off");
    a_lock_manual_zero: assert property (rd_ack && ri_q == BW_CTL_IDX && !au_q |-> !rdata[LOCK_BIT])
        else $error("lock visible in manual mode");
    a_reset_defaults: assert property (rd_ack && ri_q == LOOP_CTL_IDX && !w0_q |-> rdata[5:0] == 6'h20)
        else $error("loop control not at reset value");
endmodule

// ===== verification/tb.sv
/*
 * Self-checking bench: host controller and device joined by the link.
 * Assumes a 4 ns clk_sys; source clocks are made here in step with it.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pcs_pkg::*;
    typedef struct packed {
        logic w;
        logic [1:0] i;
        logic [7:0] d;
        logic [7:0] x;
    } pcs_row_s;
    logic clk_sys = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, r;
    logic [31:0] pwdata = 32'h0, prdata, s;
    logic pready, pslverr, osc_en, run_stop, e, base_clock_out, lock_interrupt, osc_enable_out, loop_enable_out;
    logic crystal_clock = 1'b0, vco_clock = 1'b0, vco_locked = 1'b0, mon = 1'b0, win = 1'b0, seen = 1'b0;
    logic last_b = 1'b0;
    int n_errors = 0, n_compared = 0, cyc = 0, run_len = 0, min_run = 999, max_run = 0, tog = 0, high = 0;
    pcs_row_s rows [18] = '{
        '{1'b0, 2'h0, 8'h00, 8'h20}, '{1'b0, 2'h1, 8'h00, 8'h00}, '{1'b0, 2'h2, 8'h00, 8'h40},
        '{1'b0, 2'h3, 8'h00, 8'h00}, '{1'b1, 2'h3, 8'hFF, 8'h00},
        '{1'b1, 2'h0, 8'h8E, 8'h00},
        '{1'b1, 2'h2, 8'h00, 8'h00}, '{1'b1, 2'h0, 8'h0E, 8'h0E}, '{1'b1, 2'h0, 8'h2E, 8'h2E},
        '{1'b1, 2'h0, 8'h3E, 8'h2E}, '{1'b1, 2'h2, 8'h80, 8'h00},
        '{1'b1, 2'h0, 8'h0E, 8'h0E}, '{1'b1, 2'h2, 8'h80, 8'h80},
        '{1'b1, 2'h0, 8'h3E, 8'h2E}, '{1'b1, 2'h0, 8'h3E, 8'h3E},
        '{1'b1, 2'h0, 8'h1E, 8'h3E}, '{1'b1, 2'h1, 8'h80, 8'h80}, '{1'b1, 2'h0, 8'hBE, 8'hBE}
    };
    pcs_link_if lnk ();
    pcs_loop_dev #(.SWITCH_EDGES(3)) pcs_loop_dev_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(lnk),
        .crystal_clock(crystal_clock), .vco_clock(vco_clock), .vco_locked(vco_locked),
        .oscillator_enable_in(osc_en), .osc_run_in_stop(run_stop), .base_clock_out(base_clock_out),
        .lock_interrupt(lock_interrupt), .osc_enable_out(osc_enable_out), .loop_enable_out(loop_enable_out));
    pcs_apb_ctl pcs_apb_ctl_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .oscillator_enable_out(osc_en), .osc_run_in_stop_out(run_stop), .link(lnk));
    pcs_assertions pcs_assertions_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .req(lnk.req), .wr(lnk.wr),
        .idx(lnk.idx), .wdata(lnk.wdata), .rdata(lnk.rdata), .ack(lnk.ack));
    // ----------------------------------------
    // Clocks, sources and output monitor
    // ----------------------------------------
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        crystal_clock <= (cyc % 8) < 4;
        vco_clock <= (cyc % 6) < 3;
    end
    always @(negedge clk_sys) begin
        if (mon && base_clock_out !== last_b) begin
            if (seen && run_len < min_run) min_run = run_len;
            if (seen && run_len > max_run) max_run = run_len;
            seen = 1'b1;
            run_len = 0;
            if (win) tog++;
        end
        run_len++;
        if (win && base_clock_out === 1'b1) high++;
        last_b = base_clock_out;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic cmp(input logic [7:0] g, input logic [7:0] x, input string m);
        n_compared++;
        if (g !== x) begin
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, x);
            n_errors++;
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic er);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) cmp(8'h00, 8'h01, "no pready");
        q = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic dev_acc(input logic w, input logic [1:0] i, input logic [7:0] d, output logic [7:0] q);
        logic [31:0] st;
        logic er;
        int n;
        n = 0;
        apb(1'b1, CMD_OFS, {15'h0000, w, 6'h00, i, d}, st, er);
        do begin
            apb(1'b0, STAT_OFS, 32'h0, st, er);
            n++;
        end while (st[STAT_BUSY_BIT] !== 1'b0 && n < 20);
        if (n >= 20) cmp(8'h00, 8'h01, "stuck busy");
        q = st[7:0];
    endtask
    task automatic measure(input logic [7:0] xt, input string m);
        repeat (30) @(posedge clk_sys);
        tog = 0;
        high = 0;
        win = 1'b1;
        repeat (96) @(posedge clk_sys);
        win = 1'b0;
        cmp(tog[7:0], xt, m);
        cmp(high[7:0], 8'h30, m);
    endtask
    task close_out;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #80000;
        n_errors++;
        close_out;
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        mon = 1'b1;
        measure(8'h0C, "crystal rate");
        foreach (rows[k]) begin
            dev_acc(rows[k].w, rows[k].i, rows[k].d, r);
            if (rows[k].w) dev_acc(1'b0, rows[k].i, 8'h00, r);
            cmp(r, rows[k].x, "register row");
        end
        measure(8'h10, "vco rate");
        @(posedge clk_sys);
        vco_locked <= 1'b1;
        repeat (5) @(negedge clk_sys);
        cmp({7'h00, lock_interrupt}, 8'h01, "irq raised");
        dev_acc(1'b0, LOOP_CTL_IDX, 8'h00, r);
        cmp(r, 8'hFE, "flag set");
        @(negedge clk_sys);
        cmp({7'h00, lock_interrupt}, 8'h00, "irq after read");
        dev_acc(1'b0, LOOP_CTL_IDX, 8'h00, r);
        cmp(r, 8'hBE, "flag cleared");
        dev_acc(1'b0, BW_CTL_IDX, 8'h00, r);
        cmp(r, 8'hC0, "lock seen");
        @(posedge clk_sys);
        vco_locked <= 1'b0;
        dev_acc(1'b1, BW_CTL_IDX, 8'h00, r);
        dev_acc(1'b0, LOOP_CTL_IDX, 8'h00, r);
        cmp(r, 8'h3E, "manual hides");
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, PIN_OFS, 32'(k), s, e);
            repeat (3) @(negedge clk_sys);
            cmp({7'h00, osc_enable_out}, {7'h00, k[0] | k[1]}, "osc enable");
            cmp({7'h00, loop_enable_out}, {7'h00, k[0]}, "loop enable");
        end
        apb(1'b0, 8'h0C, 32'h0, s, e);
        cmp({7'h00, e}, 8'h01, "slverr");
        cmp(s[7:0], 8'h00, "unmapped data");
        mon = 1'b0;
        cmp({7'h00, (min_run >= 6 && max_run <= 48)}, 8'h01, "switch runs");
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        dev_acc(1'b0, LOOP_CTL_IDX, 8'h00, r);
        cmp(r, 8'h20, "reset loop control");
        dev_acc(1'b0, BW_CTL_IDX, 8'h00, r);
        cmp(r, 8'h00, "reset bandwidth");
        close_out;
    end
endmodule
